// File: rtl/cycle_timer.sv
// saturating cycle counter with a compare limit
`timescale 1ns/1ps
module cycle_timer #(
  parameter int W = 20
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic clear_i,
  input wire logic [W-1:0] limit_i,
  output logic done_o
);
  logic [W-1:0] cnt_r;

  assign done_o = (cnt_r >= limit_i);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_r <= '0;
    end else if (ce_i) begin
      if (clear_i) begin
        cnt_r <= '0;
      end else if (!done_o) begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule

// File: rtl/net_cmd_pkg.sv
// shared constants of the configuration command interpreter
package net_cmd_pkg;
  // ****************************************
  // clock and times
  // ****************************************
  localparam int CLK_KHZ = 25000;
  localparam int SWITCH_WINDOW_MS = 1;
  localparam int WAKE_TIME_MS = 4;
  localparam int FULL_RESET_MS = 15;
  localparam int STACK_INIT_MS = 5;
  localparam int NV_SAVE_US = 30;
  localparam int WAKE_LOW_US = 35;
  // least times round up to whole cycles
  localparam int NV_SAVE_CYC = (NV_SAVE_US * CLK_KHZ + 999) / 1000;
  localparam int WAKE_LOW_CYC = (WAKE_LOW_US * CLK_KHZ + 999) / 1000;
  localparam int TMR_W = 20;
  // ****************************************
  // command codes
  // ****************************************
  localparam logic [7:0] line_speed_set_cmd = 8'h02;
  localparam logic [7:0] sleep_cmd = 8'h03;
  localparam logic [7:0] full_reset_cmd = 8'h05;
  localparam logic [7:0] invert_echo_cmd = 8'h06;
  localparam logic [7:0] global_event_query_cmd = 8'h29;
  localparam logic [7:0] link_mode_cmd = 8'h20;
  localparam logic [7:0] hw_address_set_cmd = 8'h21;
  localparam logic [7:0] host_address_set_cmd = 8'h22;
  localparam logic [7:0] gateway_set_cmd = 8'h23;
  localparam logic [7:0] mask_set_cmd = 8'h24;
  localparam logic [7:0] rx_filter_set_cmd = 8'h25;
  localparam logic [7:0] phy_status_query_cmd = 8'h26;
  localparam logic [7:0] stack_init_cmd = 8'h27;
  localparam logic [7:0] unreachable_info_query_cmd = 8'h28;
  // ****************************************
  // lengths, codes, reset values
  // ****************************************
  localparam logic [3:0] LEN_NONE = 4'h0;
  localparam logic [3:0] LEN_ONE = 4'h1;
  localparam logic [3:0] LEN_SPEED = 4'h3;
  localparam logic [3:0] LEN_ADDR = 4'h4;
  localparam logic [3:0] LEN_HW = 4'h6;
  localparam logic [3:0] LEN_UNREACH = 4'h8;
  localparam logic [3:0] LEN_FILTER = 4'h9;
  localparam logic [7:0] RESULT_OK = 8'h00;
  localparam logic [23:0] SPEED_DEFAULT = 24'h00_2580;
  localparam logic [7:0] LINK_AUTO = 8'h20;
  localparam logic [31:0] MASK_DEFAULT = 32'h00FF_FFFF;
  localparam logic [4:0] FILTER_DEFAULT = 5'h19;
  localparam int FLT_GROUP_BIT = 2;
  localparam logic [2:0] STRAP_FLOAT = 3'h7;
  localparam logic [5:0] PIN_IDLE = 6'h3F;
  localparam logic [2:0] BOOT_TAKE = 3'h3;
  localparam logic [1:0] HOST_SERIAL = 2'h0;
  localparam logic [1:0] HOST_SPI = 2'h1;
endpackage

// File: rtl/net_stack_config_commands.sv
// configuration and status command interpreter of the network stack device
// How it works
// - floating straps give 9600 bps after reset
// - speed is coefficients 2,1,0 as bytes
// - answer at new speed after switch window
// - sleep powers down mac, phy, link
// - wake after select or rx low 35us
// - wake takes 4 ms, bytes ignored
// - full reset holds about 15 ms
// - echo returns complement of its byte
// - link mode codes, auto negotiation default
// - link mode change restarts mac and phy
// - six byte hardware address saved, 30us
// - address bytes stored low byte first
// - mask defaults to 255.255.255.0
// - filter byte bits 4 to 0
// - filter reset: broadcast, receive, transmit on
// - group table used only with multicast
// - phy query returns one code byte
// - init takes about 5 ms, busy meanwhile
// - unreachable reply: code, protocol, port, address
// - global status bits seven to one
// - bit zero flags recorded unreachable event
// - answered status clears, interrupt released
`timescale 1ns/1ps
module net_stack_config_commands
  import net_cmd_pkg::*;
#(
  parameter int SWITCH_CYC = SWITCH_WINDOW_MS * CLK_KHZ,
  parameter int WAKE_CYC = WAKE_TIME_MS * CLK_KHZ,
  parameter int RESET_CYC = FULL_RESET_MS * CLK_KHZ,
  parameter int INIT_CYC = STACK_INIT_MS * CLK_KHZ,
  // arbitrary factory address
  parameter logic [47:0] HW_ADDR_INIT = 48'h0000_0000_0000,
  parameter logic [23:0] ALT_SPEED = 24'h01_C200
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [1:0] host_mode_i,
  input wire logic [2:0] strap_i,
  input wire logic serial_rx_i,
  input wire logic serial_select_n_i,
  input wire logic parallel_select_n_i,
  input wire logic rx_valid_i,
  input wire logic cmd_start_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic [7:0] phy_status_i,
  input wire logic [3:0] conn_event_i,
  input wire logic lease_event_i,
  input wire logic link_change_event_i,
  input wire logic address_clash_event_i,
  input wire logic unreach_log_i,
  input wire logic [7:0] unreach_code_i,
  input wire logic [7:0] unreach_proto_i,
  input wire logic [15:0] unreach_port_i,
  input wire logic [31:0] unreach_addr_i,
  output logic tx_valid_o,
  output logic [7:0] tx_byte_o,
  output logic [23:0] line_speed_o,
  output logic busy_o,
  output logic power_down_o,
  output logic soft_reset_o,
  output logic [7:0] link_mode_o,
  output logic link_restart_o,
  output logic [47:0] hw_addr_o,
  output logic nv_write_o,
  output logic [31:0] host_addr_o,
  output logic [31:0] gateway_o,
  output logic [31:0] mask_o,
  output logic [4:0] filter_mode_o,
  output logic [63:0] group_table_o,
  output logic stack_init_o,
  output logic irq_n_o
);
  typedef enum logic [2:0] {
    S_IDLE, S_PARAM, S_EXEC, S_WAIT, S_REPLY, S_SLEEP, S_WAKE, S_RESET
  } state_t;

  localparam logic [TMR_W-1:0] SWITCH_LIM = TMR_W'(SWITCH_CYC);
  localparam logic [TMR_W-1:0] WAKE_LIM = TMR_W'(WAKE_CYC);
  localparam logic [TMR_W-1:0] RESET_LIM = TMR_W'(RESET_CYC);
  localparam logic [TMR_W-1:0] INIT_LIM = TMR_W'(INIT_CYC);
  localparam logic [TMR_W-1:0] NV_LIM = TMR_W'(NV_SAVE_CYC);
  localparam logic [TMR_W-1:0] LOW_LIM = TMR_W'(WAKE_LOW_CYC);

  state_t state_r, state_nxt;
  logic [5:0] pins_m_r, pins_s_r;
  logic [2:0] boot_r;
  logic [7:0] cmd_r;
  logic [3:0] need_r, cnt_r, reply_len_r, new_len;
  logic [71:0] param_r;
  logic [63:0] reply_r;
  logic [7:0] status_r, status_nxt, set_vec, clr_vec;
  logic [7:0] unr_code_r, unr_proto_r;
  logic [15:0] unr_port_r;
  logic [31:0] unr_addr_r;
  logic unreach_set_r, irq_n_r;
  logic [63:0] table_r;
  logic [TMR_W-1:0] tmr_limit;
  logic new_cmd, param_in, last_param, tmr_done, wake_done, wake_line;
  logic exec_speed, exec_hw, exec_link, glob_clear, cfg_clear;

  // ****************************************
  // pin synchronisers and strap capture
  // ****************************************
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pins_m_r <= PIN_IDLE;
      pins_s_r <= PIN_IDLE;
    end else if (ce_i) begin
      pins_m_r <= {strap_i, parallel_select_n_i, serial_select_n_i, serial_rx_i};
      pins_s_r <= pins_m_r;
    end
  end

  assign wake_line = (host_mode_i == HOST_SERIAL) ? pins_s_r[0] :
                     (host_mode_i == HOST_SPI) ? pins_s_r[1] : pins_s_r[2];

  // ****************************************
  // command decode
  // ****************************************
  always_comb begin
    case (rx_byte_i)
      line_speed_set_cmd: new_len = LEN_SPEED;
      invert_echo_cmd, link_mode_cmd: new_len = LEN_ONE;
      hw_address_set_cmd: new_len = LEN_HW;
      host_address_set_cmd, gateway_set_cmd, mask_set_cmd: new_len = LEN_ADDR;
      rx_filter_set_cmd: new_len = LEN_FILTER;
      default: new_len = LEN_NONE;
    endcase
  end

  // bytes arriving while waking, resetting or busy are dropped
  assign new_cmd = rx_valid_i & cmd_start_i & (state_r == S_IDLE || state_r == S_PARAM);
  assign param_in = rx_valid_i & ~cmd_start_i & (state_r == S_PARAM);
  assign last_param = param_in & (cnt_r == need_r - 4'h1);
  assign exec_speed = (state_r == S_EXEC) & (cmd_r == line_speed_set_cmd);
  assign exec_hw = (state_r == S_EXEC) & (cmd_r == hw_address_set_cmd);
  assign exec_link = (state_r == S_EXEC) & (cmd_r == link_mode_cmd);
  assign glob_clear = (state_r == S_REPLY) & (reply_len_r == LEN_ONE)
                      & (cmd_r == global_event_query_cmd);
  assign cfg_clear = (state_r == S_RESET) & tmr_done;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE, S_PARAM: begin
        if (new_cmd && new_len != LEN_NONE) begin
          state_nxt = S_PARAM;
        end else if (new_cmd) begin
          case (rx_byte_i)
            sleep_cmd: state_nxt = S_SLEEP;
            full_reset_cmd: state_nxt = S_RESET;
            stack_init_cmd: state_nxt = S_WAIT;
            phy_status_query_cmd, unreachable_info_query_cmd,
            global_event_query_cmd: state_nxt = S_REPLY;
            default: state_nxt = S_IDLE;
          endcase
        end else if (last_param) begin
          state_nxt = S_EXEC;
        end
      end
      S_EXEC: begin
        if (exec_speed || exec_hw) begin
          state_nxt = S_WAIT;
        end else if (cmd_r == invert_echo_cmd) begin
          state_nxt = S_REPLY;
        end else begin
          state_nxt = S_IDLE;
        end
      end
      S_WAIT: begin
        if (tmr_done) begin
          state_nxt = (reply_len_r != LEN_NONE) ? S_REPLY : S_IDLE;
        end
      end
      S_REPLY: begin
        if (reply_len_r == LEN_ONE) begin
          state_nxt = S_IDLE;
        end
      end
      S_SLEEP: begin
        if (wake_done) begin
          state_nxt = S_WAKE;
        end
      end
      S_WAKE, S_RESET: begin
        if (tmr_done) begin
          state_nxt = S_IDLE;
        end
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  // ****************************************
  // timers
  // ****************************************
  assign tmr_limit = (state_r == S_WAKE) ? WAKE_LIM :
                     (state_r == S_RESET) ? RESET_LIM :
                     (cmd_r == line_speed_set_cmd) ? SWITCH_LIM :
                     (cmd_r == hw_address_set_cmd) ? NV_LIM : INIT_LIM;

  cycle_timer #(.W(TMR_W)) step_timer (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .clear_i(state_nxt != state_r),
    .limit_i(tmr_limit),
    .done_o(tmr_done)
  );

  // any high sample restarts the low-time count
  cycle_timer #(.W(TMR_W)) wake_timer (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .clear_i(wake_line || state_r != S_SLEEP),
    .limit_i(LOW_LIM),
    .done_o(wake_done)
  );

  // ****************************************
  // command state, parameters and replies
  // ****************************************
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= S_IDLE;
      cmd_r <= 8'h00;
      need_r <= LEN_NONE;
      cnt_r <= LEN_NONE;
      param_r <= '0;
      reply_r <= '0;
      reply_len_r <= LEN_NONE;
    end else if (ce_i) begin
      state_r <= state_nxt;
      if (new_cmd) begin
        cmd_r <= rx_byte_i;
        need_r <= new_len;
        cnt_r <= LEN_NONE;
        param_r <= '0;
        reply_len_r <= LEN_ONE;
        case (rx_byte_i)
          phy_status_query_cmd: reply_r <= {56'h0, phy_status_i};
          global_event_query_cmd: reply_r <= {56'h0, status_r};
          unreachable_info_query_cmd: begin
            reply_r <= {unr_addr_r, unr_port_r, unr_proto_r, unr_code_r};
            reply_len_r <= LEN_UNREACH;
          end
          default: reply_len_r <= LEN_NONE;
        endcase
      end else if (param_in) begin
        param_r[{cnt_r, 3'b000} +: 8] <= rx_byte_i;
        cnt_r <= cnt_r + 4'h1;
      end else if (state_r == S_EXEC) begin
        reply_len_r <= (exec_speed || cmd_r == invert_echo_cmd) ? LEN_ONE : LEN_NONE;
        reply_r <= exec_speed ? {56'h0, RESULT_OK} : {56'h0, ~param_r[7:0]};
      end else if (state_r == S_REPLY) begin
        reply_r <= reply_r >> 8;
        reply_len_r <= reply_len_r - 4'h1;
      end
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      boot_r <= 3'h0;
      line_speed_o <= SPEED_DEFAULT;
      link_mode_o <= LINK_AUTO;
      hw_addr_o <= HW_ADDR_INIT;
      host_addr_o <= 32'h0000_0000;
      gateway_o <= 32'h0000_0000;
      mask_o <= MASK_DEFAULT;
      filter_mode_o <= FILTER_DEFAULT;
      table_r <= '0;
    end else if (ce_i) begin
      boot_r <= cfg_clear ? 3'h0 : {boot_r[1:0], 1'b1};
      if (boot_r == BOOT_TAKE) begin
        line_speed_o <= (pins_s_r[5:3] == STRAP_FLOAT) ? SPEED_DEFAULT : ALT_SPEED;
      end else if (exec_speed) begin
        line_speed_o <= param_r[23:0];
      end
      if (cfg_clear) begin
        link_mode_o <= LINK_AUTO;
        host_addr_o <= 32'h0000_0000;
        gateway_o <= 32'h0000_0000;
        mask_o <= MASK_DEFAULT;
        filter_mode_o <= FILTER_DEFAULT;
        table_r <= '0;
      end else if (state_r == S_EXEC) begin
        case (cmd_r)
          link_mode_cmd: link_mode_o <= param_r[7:0];
          hw_address_set_cmd: hw_addr_o <= param_r[47:0];
          host_address_set_cmd: host_addr_o <= param_r[31:0];
          gateway_set_cmd: gateway_o <= param_r[31:0];
          mask_set_cmd: mask_o <= param_r[31:0];
          rx_filter_set_cmd: begin
            filter_mode_o <= param_r[4:0];
            table_r <= param_r[71:8];
          end
          default: table_r <= table_r;
        endcase
      end
    end
  end

  // ****************************************
  // event status and outputs
  // ****************************************
  assign set_vec = {conn_event_i, lease_event_i, link_change_event_i,
                    address_clash_event_i, unreach_set_r};
  // a status answer clears only the bits that were reported, so a late event survives; full reset clears all
  assign clr_vec = cfg_clear ? 8'hFF : (glob_clear ? reply_r[7:0] : 8'h00);
  assign status_nxt = (status_r & ~clr_vec) | set_vec;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      status_r <= 8'h00;
      irq_n_r <= 1'b1;
      unreach_set_r <= 1'b0;
      unr_code_r <= 8'h00;
      unr_proto_r <= 8'h00;
      unr_port_r <= 16'h0000;
      unr_addr_r <= 32'h0000_0000;
    end else if (ce_i) begin
      status_r <= status_nxt;
      irq_n_r <= ~|status_nxt;
      unreach_set_r <= unreach_log_i;
      if (unreach_log_i) begin
        unr_code_r <= unreach_code_i;
        unr_proto_r <= unreach_proto_i;
        unr_port_r <= unreach_port_i;
        unr_addr_r <= unreach_addr_i;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_valid_o <= 1'b0;
      tx_byte_o <= 8'h00;
      busy_o <= 1'b0;
      power_down_o <= 1'b0;
      soft_reset_o <= 1'b0;
      link_restart_o <= 1'b0;
      nv_write_o <= 1'b0;
      stack_init_o <= 1'b0;
      group_table_o <= '0;
    end else if (ce_i) begin
      tx_valid_o <= (state_r == S_REPLY);
      tx_byte_o <= reply_r[7:0];
      busy_o <= (state_nxt == S_WAIT || state_nxt == S_WAKE || state_nxt == S_RESET);
      power_down_o <= (state_nxt == S_SLEEP);
      soft_reset_o <= (state_nxt == S_RESET);
      link_restart_o <= exec_link;
      nv_write_o <= exec_hw;
      stack_init_o <= new_cmd && rx_byte_i == stack_init_cmd;
      group_table_o <= filter_mode_o[FLT_GROUP_BIT] ? table_r : 64'h0;
    end
  end
  assign irq_n_o = irq_n_r;

  // ****************************************
  // assertions
  // ****************************************
  logic [TMR_W-1:0] low_cnt_r;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      low_cnt_r <= '0;
    end else if (ce_i) begin
      low_cnt_r <= wake_line ? '0 : low_cnt_r + TMR_W'(low_cnt_r != '1);
    end
  end

  default clocking cb @(posedge clk_i iff ce_i); endclocking
  default disable iff (reset_i);

  sequence echo_byte_s;
    state_r == S_PARAM && cmd_r == invert_echo_cmd && last_param;
  endsequence
  sequence switch_end_s;
    state_r == S_WAIT && cmd_r == line_speed_set_cmd && tmr_done;
  endsequence

  boot_speed_a: assert property (
    boot_r == BOOT_TAKE && pins_s_r[5:3] == STRAP_FLOAT |=> line_speed_o == SPEED_DEFAULT
  ) else $error("default line speed not taken");
  speed_load_a: assert property (
    exec_speed |=> line_speed_o == $past(param_r[23:0])
  ) else $error("line speed not built from coefficients");
  switch_hold_a: assert property (
    exec_speed |=> (!tx_valid_o && state_r == S_WAIT) [*8]
  ) else $error("speed answer sent inside switch window");
  switch_reply_a: assert property (
    switch_end_s |=> ##1 tx_valid_o && tx_byte_o == RESULT_OK
  ) else $error("speed answer missing after window");
  sleep_power_a: assert property (
    state_r == S_SLEEP |-> power_down_o && !tx_valid_o
  ) else $error("sleep without power down");
  wake_low_a: assert property (
    state_r == S_SLEEP && state_nxt == S_WAKE |-> low_cnt_r >= LOW_LIM
  ) else $error("woken by short low pulse");
  wake_quiet_a: assert property (
    state_r == S_WAKE |=> state_r == S_WAKE || state_r == S_IDLE
  ) else $error("command parsed while waking");
  reset_hold_a: assert property (
    state_r == S_IDLE && state_nxt == S_RESET |=> soft_reset_o [*8]
  ) else $error("full reset not held");
  echo_a: assert property (
    echo_byte_s |-> ##3 tx_valid_o && tx_byte_o == ~$past(rx_byte_i, 3)
  ) else $error("echo not complemented");
  link_restart_a: assert property (
    exec_link |=> link_restart_o && link_mode_o == $past(param_r[7:0])
  ) else $error("link mode change without restart");
  nv_save_a: assert property (
    exec_hw |=> nv_write_o && hw_addr_o == $past(param_r[47:0])
  ) else $error("hardware address not saved");
  group_gate_a: assert property (
    !filter_mode_o[FLT_GROUP_BIT] |=> group_table_o == 64'h0
  ) else $error("group table used with multicast off");
  unreach_flag_a: assert property (
    unreach_log_i |=> ##1 status_r[0]
  ) else $error("unreachable flag not raised");
  irq_level_a: assert property (
    irq_n_o == (status_r == 8'h00)
  ) else $error("interrupt level disagrees with status");
endmodule

// File: test/host_port_model.sv
// host controller model on the byte port of the command interpreter
`timescale 1ns/1ps
module host_port_model
  import net_cmd_pkg::*;
(
  input wire logic clk_i,
  output logic rx_valid_o,
  output logic cmd_start_o,
  output logic [7:0] rx_byte_o,
  output logic select_n_o
);
  initial begin
    rx_valid_o = 1'b0;
    cmd_start_o = 1'b0;
    rx_byte_o = 8'h00;
    select_n_o = 1'b0;
  end
  // one byte per two cycles, strobe held until the taking edge has passed
  task automatic put(input logic c, input logic [7:0] b);
    @(posedge clk_i);
    #1;
    rx_valid_o = 1'b1;
    cmd_start_o = c;
    rx_byte_o = b;
    @(posedge clk_i);
    #1;
    rx_valid_o = 1'b0;
    cmd_start_o = 1'b0;
    // a released bus must not keep showing the last byte
    rx_byte_o = ~b;
  endtask
  task automatic sleep_req();
    put(1'b1, sleep_cmd);
    select_n_o = 1'b1;
  endtask
  // chip select level, changed just after an edge like every other request
  task automatic set_select(input logic v);
    @(posedge clk_i);
    #1;
    select_n_o = v;
  endtask
endmodule

// File: test/net_stack_config_commands_test.sv
// self-checking bench of the configuration command interpreter
`timescale 1ns/1ps
module net_stack_config_commands_test
  import net_cmd_pkg::*;
;
  logic clk_i, reset_i, srx, rv, cs, sel_n, lev, lcev, acev, ulog;
  logic tv, busy, pd, sr, lr, nvw, si, irq_n;
  logic [3:0] cev;
  logic [7:0] rb, phy, ucode, uproto, tx, lm;
  logic [15:0] uport;
  logic [31:0] uaddr, ha, gw, mk;
  logic [23:0] spd;
  logic [47:0] hw;
  logic [4:0] fm;
  logic ce;
  logic [1:0] hm;
  logic [63:0] gt;
  int failures = 0;
  int n_checks = 0;

  host_port_model host_port_model_inst (.clk_i(clk_i), .rx_valid_o(rv), .cmd_start_o(cs),
    .rx_byte_o(rb), .select_n_o(sel_n));

  net_stack_config_commands #(.SWITCH_CYC(16), .WAKE_CYC(20), .RESET_CYC(30), .INIT_CYC(20))
  net_stack_config_commands_inst (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce),
    .host_mode_i(hm), .strap_i(3'h7), .serial_rx_i(srx), .serial_select_n_i(sel_n),
    .parallel_select_n_i(1'b1), .rx_valid_i(rv), .cmd_start_i(cs), .rx_byte_i(rb),
    .phy_status_i(phy), .conn_event_i(cev), .lease_event_i(lev), .link_change_event_i(lcev),
    .address_clash_event_i(acev), .unreach_log_i(ulog), .unreach_code_i(ucode),
    .unreach_proto_i(uproto), .unreach_port_i(uport), .unreach_addr_i(uaddr),
    .tx_valid_o(tv), .tx_byte_o(tx), .line_speed_o(spd), .busy_o(busy), .power_down_o(pd),
    .soft_reset_o(sr), .link_mode_o(lm), .link_restart_o(lr), .hw_addr_o(hw),
    .nv_write_o(nvw), .host_addr_o(ha), .gateway_o(gw), .mask_o(mk), .filter_mode_o(fm),
    .group_table_o(gt), .stack_init_o(si), .irq_n_o(irq_n));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic step();
    @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, s, e);
    end
  endtask
  // next answer byte; a missing answer returns unknown and fails the compare
  task automatic rd(output logic [7:0] b);
    for (int i = 0; i < 100 && tv !== 1'b1; i++) step();
    b = (tv === 1'b1) ? tx : 8'hxx;
    step();
  endtask
  task automatic put(input logic c, input logic [7:0] b);
    host_port_model_inst.put(c, b);
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic t_defaults();
    repeat (4) step();
    chk(spd, 24'h00_2580);
    chk(lm, 8'h20);
    chk(mk, 32'h00FF_FFFF);
    chk(fm, 5'h19);
    chk(irq_n, 1'b1);
  endtask
  task automatic t_echo_speed();
    logic [7:0] b;
    put(1'b1, invert_echo_cmd);
    put(1'b0, 8'h57);
    rd(b);
    chk(b, 8'hA8);
    put(1'b1, line_speed_set_cmd);
    put(1'b0, 8'h00);
    put(1'b0, 8'hC2);
    put(1'b0, 8'h01);
    repeat (3) step();
    chk(busy, 1'b1);
    rd(b);
    chk(b, 8'h00);
    chk(spd, 24'h01_C200);
  endtask
  task automatic t_addr();
    logic [7:0] cmds [3] = '{host_address_set_cmd, gateway_set_cmd, mask_set_cmd};
    int i;
    for (int k = 0; k < 3; k++) begin
      put(1'b1, cmds[k]);
      for (int j = 0; j < 4; j++) put(1'b0, 8'(16 * k + j));
    end
    step();
    chk(ha, 32'h0302_0100);
    chk(gw, 32'h1312_1110);
    chk(mk, 32'h2322_2120);
    put(1'b1, hw_address_set_cmd);
    for (int j = 0; j < 6; j++) put(1'b0, 8'(8'hA0 + j));
    for (i = 0; i < 900 && nvw !== 1'b1; i++) step();
    chk(i < 900, 1'b1);
    chk(hw, 48'hA5A4_A3A2_A1A0);
    for (i = 0; i < 900 && busy !== 1'b0; i++) step();
    chk(i > 700 && i < 800, 1'b1);
  endtask
  task automatic t_filter();
    put(1'b1, rx_filter_set_cmd);
    put(1'b0, 8'h1C);
    for (int j = 1; j < 9; j++) put(1'b0, 8'(j));
    repeat (2) step();
    chk(fm, 5'h1C);
    chk(gt, 64'h0807_0605_0403_0201);
    put(1'b1, rx_filter_set_cmd);
    for (int j = 0; j < 9; j++) put(1'b0, (j == 0) ? 8'hF9 : 8'hFF);
    repeat (2) step();
    chk(fm, 5'h19);
    chk(gt, 64'h0);
    // group index 32 lands on bit 0 of the high table half
    put(1'b1, rx_filter_set_cmd);
    for (int j = 0; j < 9; j++) put(1'b0, (j == 0) ? 8'h1C : ((j == 5) ? 8'h01 : 8'h00));
    repeat (2) step();
    chk(gt, 64'h0000_0001_0000_0000);
  endtask
  task automatic t_link_phy();
    logic [7:0] codes [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20};
    logic r;
    logic [7:0] b;
    for (int k = 0; k < 6; k++) begin
      put(1'b1, link_mode_cmd);
      put(1'b0, codes[k]);
      r = 1'b0;
      repeat (5) begin
        r = r | (lr === 1'b1);
        step();
      end
      chk(lm, codes[k]);
      chk(r, 1'b1);
      if (k < 5) begin
        phy = codes[k];
        put(1'b1, phy_status_query_cmd);
        rd(b);
        chk(b, codes[k]);
      end
    end
  endtask
  task automatic t_status();
    logic [7:0] b;
    logic [7:0] e [8] = '{8'h03, 8'h11, 8'h34, 8'h12, 8'h0D, 8'h0C, 8'h0B, 8'h0A};
    cev = 4'hA;
    lcev = 1'b1;
    {lev, acev} = 2'h3;
    step();
    cev = 4'h0;
    lcev = 1'b0;
    {lev, acev} = 2'h0;
    step();
    chk(irq_n, 1'b0);
    put(1'b1, global_event_query_cmd);
    rd(b);
    chk(b, 8'hAE);
    chk(irq_n, 1'b1);
    put(1'b1, global_event_query_cmd);
    rd(b);
    chk(b, 8'h00);
    ulog = 1'b1;
    step();
    ulog = 1'b0;
    repeat (2) step();
    put(1'b1, unreachable_info_query_cmd);
    for (int j = 0; j < 8; j++) begin
      rd(b);
      chk(b, e[j]);
    end
    put(1'b1, global_event_query_cmd);
    rd(b);
    chk(b, 8'h01);
  endtask
  task automatic t_power();
    logic [7:0] b;
    int i;
    put(1'b1, stack_init_cmd);
    chk(si, 1'b1);
    chk(busy, 1'b1);
    // a low enable freezes the init timer, so busy outlasts its count
    ce = 1'b0;
    repeat (40) step();
    chk(busy, 1'b1);
    ce = 1'b1;
    for (i = 0; i < 100 && busy !== 1'b0; i++) step();
    chk(busy, 1'b0);
    host_port_model_inst.sleep_req();
    step();
    chk(pd, 1'b1);
    srx = 1'b0;
    for (i = 0; i < 1000 && busy !== 1'b1; i++) step();
    chk(i >= 875 && i < 1000, 1'b1);
    srx = 1'b1;
    put(1'b1, invert_echo_cmd);
    put(1'b0, 8'h55);
    for (i = 0; i < 100 && busy !== 1'b0; i++) begin
      chk(tv, 1'b0);
      step();
    end
    put(1'b1, invert_echo_cmd);
    put(1'b0, 8'h3C);
    rd(b);
    chk(b, 8'hC3);
    put(1'b1, full_reset_cmd);
    for (i = 0; i < 10 && sr !== 1'b1; i++) step();
    chk(sr, 1'b1);
    for (i = 0; i < 100 && sr !== 1'b0; i++) step();
    repeat (4) step();
    chk(mk, 32'h00FF_FFFF);
    chk(spd, 24'h00_2580);
  endtask
  task automatic t_spi_wake();
    logic [7:0] b;
    int i;
    hm = HOST_SPI;
    host_port_model_inst.sleep_req();
    // a short select pulse must not wake the device
    host_port_model_inst.set_select(1'b0);
    repeat (100) step();
    host_port_model_inst.set_select(1'b1);
    repeat (4) step();
    chk(pd, 1'b1);
    chk(busy, 1'b0);
    host_port_model_inst.set_select(1'b0);
    for (i = 0; i < 1000 && busy !== 1'b1; i++) step();
    chk(i >= 875 && i < 1000, 1'b1);
    for (i = 0; i < 100 && busy !== 1'b0; i++) step();
    chk(pd, 1'b0);
    put(1'b1, invert_echo_cmd);
    put(1'b0, 8'hF0);
    rd(b);
    chk(b, 8'h0F);
  endtask

  initial begin
    reset_i = 1'b1;
    {srx, lev, acev} = 3'h7;
    {lcev, ulog} = 2'h0;
    cev = 4'h0;
    ce = 1'b1;
    hm = HOST_SERIAL;
    phy = 8'h01;
    {ucode, uproto, uport, uaddr} = 64'h0311_1234_0A0B_0C0D;
    repeat (5) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    {lev, acev} = 2'h0;
    t_defaults();
    t_echo_speed();
    t_addr();
    t_filter();
    t_link_phy();
    t_status();
    t_power();
    t_spi_wake();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    conclude();
  end
endmodule
